// ---- verilog/sfi_consts.svh ----
// Constants of the serial flash instruction block: opcodes, address window,
// reset values and wake timing.
// Assumes a 50 MHz system clock that samples the serial bus pins.
`ifndef SFI_CONSTS_SVH
`define SFI_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// Instruction codes
`define SFI_OP_WAKE_ID       8'hab
`define SFI_OP_MAKER_PART    8'h90
`define SFI_OP_LONG_ID       8'h9f
`define SFI_OP_SLEEP         8'hb9
`define SFI_OP_SECURE_ENTER  8'h3a
`define SFI_OP_WRITE_DISABLE 8'h04
`define SFI_OP_STATUS_WRITE  8'h01
`define SFI_OP_SECTOR_ERASE  8'h20

////////////////////////////////////////////////////////////////////////////////
// Field sizes and addresses
`define SFI_OPCODE_LAST_BIT  5'd7
`define SFI_ARG_LAST_BIT     5'd23
`define SFI_DATA_BYTE_BITS   5'd8
`define SFI_BYTE_LAST_BIT    3'd7
`define SFI_ORDER_SWAP_ADDR  24'h000001
`define SFI_SECURE_BASE      24'h07f000
`define SFI_SECURE_LAST      24'h07f0ff
`define SFI_BP_CLEAR         3'h0
`define SFI_LONG_ID_LAST     2'h2

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define SFI_SLEEP_RST        1'b0
`define SFI_SECURE_RST       1'b0

////////////////////////////////////////////////////////////////////////////////
// Wake timing; longest times, so the cycle counts round down
`define SFI_CLK_MHZ          50
`define SFI_SHORT_WAKE_NS    3000
`define SFI_LONG_WAKE_NS     5000
`define SFI_SHORT_WAKE_CYC   ((`SFI_SHORT_WAKE_NS * `SFI_CLK_MHZ) / 1000)
`define SFI_LONG_WAKE_CYC    ((`SFI_LONG_WAKE_NS * `SFI_CLK_MHZ) / 1000)

`endif

// ---- verilog/sfi_pkg.sv ----
// Types of the serial flash instruction block.
// Assumes sfi_consts.svh supplies every numeric constant.
`default_nettype none

package sfi_pkg;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic di;
  } sfi_pins_s;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_OPCODE = 5'h02,
    ST_ARGS   = 5'h04,
    ST_SEND   = 5'h08,
    ST_IGNORE = 5'h10
  } sfi_state_e;

  typedef enum logic [1:0] {
    CMD_NONE       = 2'h0,
    CMD_WAKE_ID    = 2'h1,
    CMD_MAKER_PART = 2'h2,
    CMD_LONG_ID    = 2'h3
  } sfi_cmd_e;

  typedef struct packed {
    logic [7:0] maker;
    logic [7:0] mem_type;
    logic [7:0] capacity;
    logic [7:0] part;
  } sfi_ids_s;

endpackage

`default_nettype wire

// ---- verilog/sfi_pin_sync.sv ----
// Two-stage synchroniser for the serial bus input pins.
// Assumes the pins are asynchronous to clk_in.
`timescale 1ns/100ps
`default_nettype none

module sfi_pin_sync (
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // Pins
  input  wire sfi_pkg::sfi_pins_s pins_in,
  output var  sfi_pkg::sfi_pins_s pins_out
);
  import sfi_pkg::*;

  logic [2:0] meta_r;
  logic [2:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_bit
      // Deselected and idle-high levels at reset keep the frame closed
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          meta_r[g] <= 1'b1;
          sync_r[g] <= 1'b1;
        end else begin
          meta_r[g] <= pins_in[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign pins_out = sync_r;

endmodule // sfi_pin_sync

`default_nettype wire

// ---- verilog/sfi_wake_timer.sv ----
// Wake delay counter: runs the short or long delay after a wake request.
// Assumes start_in is a one-cycle pulse on clk_in.
`timescale 1ns/100ps
`default_nettype none
`include "sfi_consts.svh"

module sfi_wake_timer (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  // Control
  input  wire logic start_in,
  input  wire logic long_in,
  // Status
  output logic      running_out,
  output logic      done_out
);

  logic [15:0] cnt_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_r <= 16'h0000;
    end else if (start_in) begin
      cnt_r <= long_in ? 16'(`SFI_LONG_WAKE_CYC) : 16'(`SFI_SHORT_WAKE_CYC);
    end else if (cnt_r != 16'h0000) begin
      cnt_r <= cnt_r - 16'h0001;
    end
  end

  assign running_out = (cnt_r != 16'h0000);
  assign done_out    = (cnt_r == 16'h0001);

endmodule // sfi_wake_timer

`default_nettype wire

// ---- verilog/sfi_instr.sv ----
// Serial flash instruction logic: wake and identify, identifier reads,
// sleep entry and secure-sector mode with its program/erase gate.
// Assumes SPI mode 0 or 3 pins sampled by clk_in, and array engines that
// report their busy state and consult pe_allow_out before each operation.
`timescale 1ns/100ps
`default_nettype none
`include "sfi_consts.svh"

module sfi_instr #(
  parameter logic [7:0] MAKER_ID = 8'h5a,  // Arbitrary value
  parameter logic [7:0] TYPE_ID  = 8'h31,  // Arbitrary value
  parameter logic [7:0] CAP_ID   = 8'h13,  // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h12   // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Serial bus
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_di_in,
  output logic             spi_do_out,
  output logic             spi_do_oe_out,
  // Array engine state
  input  wire logic        erase_prog_busy_in,
  input  wire logic        status_write_busy_in,
  input  wire logic [2:0]  block_protect_bits_in,
  input  wire logic        status_protect_bit_in,
  input  wire logic        seal_bit_in,
  // Program/erase request check
  input  wire logic [23:0] pe_addr_in,
  input  wire logic [7:0]  pe_opcode_in,
  input  wire logic        pe_is_erase_in,
  // Mode and gate outputs
  output logic             sleep_out,
  output logic             waking_out,
  output logic             secure_mode_out,
  output logic             status_protect_view_out,
  output logic             secure_sector_hit_out,
  output logic             pe_allow_out,
  output logic             seal_program_out,
  output logic             status_data_discard_out
);
  import sfi_pkg::*;

  localparam sfi_ids_s IDS = '{maker: MAKER_ID, mem_type: TYPE_ID,
                               capacity: CAP_ID, part: PART_ID};

  // Byte to send for a given command and byte position
  function automatic logic [7:0] id_byte(input sfi_cmd_e cmd, input logic [1:0] idx,
                                         input logic swap);
    logic [7:0] b;
    b = IDS.part;
    case (cmd)
      CMD_MAKER_PART: b = (idx[0] ^ swap) ? IDS.part : IDS.maker;
      CMD_LONG_ID:    b = (idx == 2'h0) ? IDS.maker :
                          (idx == 2'h1) ? IDS.mem_type : IDS.capacity;
      default:        b = IDS.part;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling and edge detection
  sfi_pins_s  pins_raw;
  sfi_pins_s  pins_s;
  logic       sclk_d_r;
  logic       cs_n_d_r;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_fall;
  logic       cs_rise;

  assign pins_raw = '{cs_n: spi_cs_n_in, sclk: spi_sclk_in, di: spi_di_in};

  sfi_pin_sync u_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .pins_in    (pins_raw),
    .pins_out   (pins_s)
  );

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_d_r <= 1'b1;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= pins_s.sclk;
      cs_n_d_r <= pins_s.cs_n;
    end
  end

  assign sclk_rise = pins_s.sclk & ~sclk_d_r & ~pins_s.cs_n;
  assign sclk_fall = ~pins_s.sclk & sclk_d_r & ~pins_s.cs_n;
  assign cs_fall   = ~pins_s.cs_n & cs_n_d_r;
  assign cs_rise   = pins_s.cs_n & ~cs_n_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode and shifting
  sfi_state_e state_r;
  sfi_cmd_e   cmd_r;
  logic [4:0] bit_cnt_r;
  logic [7:0] op_r;
  logic [23:0] arg_r;
  logic [1:0] byte_idx_r;
  logic       swap_r;
  logic [7:0] sh_r;
  logic       do_r;
  logic       oe_r;
  logic       sleep_r;
  logic       secure_r;
  logic       busy_any;
  logic [7:0] op_full;
  logic [23:0] arg_full;
  logic       op_done;
  logic       arg_done;
  logic [1:0] idx_next;
  logic       bare_opcode;

  assign busy_any    = erase_prog_busy_in | status_write_busy_in;
  assign op_full     = {op_r[6:0], pins_s.di};
  assign arg_full    = {arg_r[22:0], pins_s.di};
  assign op_done     = (state_r == ST_OPCODE) && sclk_rise && (bit_cnt_r == `SFI_OPCODE_LAST_BIT);
  assign arg_done    = (state_r == ST_ARGS) && sclk_rise && (bit_cnt_r == `SFI_ARG_LAST_BIT)
                       && (cmd_r != CMD_NONE);
  assign idx_next    = ((cmd_r == CMD_LONG_ID) && (byte_idx_r == `SFI_LONG_ID_LAST)) ?
                       2'h0 : byte_idx_r + 2'h1;
  assign bare_opcode = (state_r == ST_ARGS) && (bit_cnt_r == 5'd0);

  logic waking;
  logic wake_done;
  logic wake_start;
  logic wake_long;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r    <= ST_IDLE;
      cmd_r      <= CMD_NONE;
      bit_cnt_r  <= 5'd0;
      op_r       <= 8'h00;
      arg_r      <= 24'h000000;
      byte_idx_r <= 2'h0;
      swap_r     <= 1'b0;
      sh_r       <= 8'h00;
    end else if (cs_rise) begin
      state_r <= ST_IDLE;
    end else if (cs_fall) begin
      state_r   <= ST_OPCODE;
      cmd_r     <= CMD_NONE;
      bit_cnt_r <= 5'd0;
    end else begin
      case (state_r)
        ST_OPCODE: begin
          if (sclk_rise) begin
            op_r      <= op_full;
            bit_cnt_r <= bit_cnt_r + 5'd1;
          end
          if (op_done) begin
            bit_cnt_r <= 5'd0;
            if (waking || (sleep_r && op_full != `SFI_OP_WAKE_ID)) begin
              state_r <= ST_IGNORE;
            end else begin
              case (op_full)
                `SFI_OP_WAKE_ID: begin
                  state_r <= busy_any ? ST_IGNORE : ST_ARGS;
                  cmd_r   <= CMD_WAKE_ID;
                end
                `SFI_OP_MAKER_PART: begin
                  state_r <= ST_ARGS;
                  cmd_r   <= CMD_MAKER_PART;
                end
                `SFI_OP_LONG_ID: begin
                  state_r    <= erase_prog_busy_in ? ST_IGNORE : ST_SEND;
                  cmd_r      <= CMD_LONG_ID;
                  byte_idx_r <= 2'h0;
                  sh_r       <= id_byte(CMD_LONG_ID, 2'h0, 1'b0);
                end
                default: begin
                  state_r <= ST_ARGS;
                end
              endcase
            end
          end
        end
        ST_ARGS: begin
          if (sclk_rise) begin
            arg_r <= arg_full;
            if (bit_cnt_r != `SFI_ARG_LAST_BIT) begin
              bit_cnt_r <= bit_cnt_r + 5'd1;
            end
          end
          if (arg_done) begin
            state_r    <= ST_SEND;
            bit_cnt_r  <= 5'd0;
            byte_idx_r <= 2'h0;
            swap_r     <= (arg_full == `SFI_ORDER_SWAP_ADDR);
            sh_r       <= id_byte(cmd_r, 2'h0,
                                  arg_full == `SFI_ORDER_SWAP_ADDR);
          end
        end
        ST_SEND: begin
          if (sclk_fall) begin
            if (bit_cnt_r[2:0] == `SFI_BYTE_LAST_BIT) begin
              bit_cnt_r  <= 5'd0;
              byte_idx_r <= idx_next;
              sh_r       <= id_byte(cmd_r, idx_next, swap_r);
            end else begin
              bit_cnt_r <= bit_cnt_r + 5'd1;
              sh_r      <= {sh_r[6:0], 1'b0};
            end
          end
        end
        ST_IGNORE: begin
          state_r <= ST_IGNORE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Output bit changes on falling serial clock edges; chip select edges clear it
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      do_r <= 1'b0;
      oe_r <= 1'b0;
    end else if (cs_rise || cs_fall) begin
      do_r <= 1'b0;
      oe_r <= 1'b0;
    end else if ((state_r == ST_SEND) && sclk_fall) begin
      do_r <= sh_r[7];
      oe_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sleep flag and wake delay
  sfi_wake_timer u_wake (
    .clk_in      (clk_in),
    .reset_n_in  (reset_n_in),
    .start_in    (wake_start),
    .long_in     (wake_long),
    .running_out (waking),
    .done_out    (wake_done)
  );

  // Deselect after the wake code from sleep starts the matching delay
  assign wake_start = cs_rise && sleep_r && !waking && (cmd_r == CMD_WAKE_ID)
                      && ((state_r == ST_ARGS) || (state_r == ST_SEND));
  assign wake_long  = !bare_opcode;

  logic sleep_entry;
  assign sleep_entry = cs_rise && bare_opcode && (op_r == `SFI_OP_SLEEP)
                       && !busy_any && !sleep_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleep_r <= `SFI_SLEEP_RST;
    end else if (sleep_entry) begin
      sleep_r <= 1'b1;
    end else if (wake_done) begin
      sleep_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Secure-sector mode
  logic secure_enter;
  logic secure_exit;
  assign secure_enter = cs_rise && bare_opcode && (op_r == `SFI_OP_SECURE_ENTER);
  assign secure_exit  = cs_rise && bare_opcode && (op_r == `SFI_OP_WRITE_DISABLE);

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      secure_r <= `SFI_SECURE_RST;
    end else if (secure_exit) begin
      secure_r <= 1'b0;
    end else if (secure_enter) begin
      secure_r <= 1'b1;
    end
  end

  // A status write in secure mode only ever sets the seal, one pulse
  logic seal_pgm_r;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seal_pgm_r <= 1'b0;
    end else begin
      seal_pgm_r <= cs_rise && secure_r && (state_r == ST_ARGS)
                    && (op_r == `SFI_OP_STATUS_WRITE)
                    && (bit_cnt_r >= `SFI_DATA_BYTE_BITS)
                    && !busy_any;
    end
  end

  // Gate for the array engines; block protect outside the sector stays theirs
  logic hit;
  logic allow;
  assign hit = secure_r && (pe_addr_in >= `SFI_SECURE_BASE)
               && (pe_addr_in <= `SFI_SECURE_LAST);
  always_comb begin
    allow = 1'b1;
    if (sleep_r || waking) begin
      allow = 1'b0;
    end else if (secure_r) begin
      if (seal_bit_in) begin
        allow = 1'b0;
      end else if (hit) begin
        allow = (block_protect_bits_in == `SFI_BP_CLEAR)
                && (!pe_is_erase_in
                    || (pe_opcode_in == `SFI_OP_SECTOR_ERASE));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign spi_do_out              = do_r;
  assign spi_do_oe_out           = oe_r;
  assign sleep_out               = sleep_r;
  assign waking_out              = waking;
  assign secure_mode_out         = secure_r;
  assign status_protect_view_out = secure_r ? seal_bit_in : status_protect_bit_in;
  assign secure_sector_hit_out   = hit;
  assign pe_allow_out            = allow;
  assign seal_program_out        = seal_pgm_r;
  assign status_data_discard_out = secure_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int WAKE_MAX = 300;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence s_sleep_op;
    op_done && sleep_r && (op_full != `SFI_OP_WAKE_ID);
  endsequence
  sequence s_wake_armed;
    wake_start;
  endsequence

  sleep_ignore_a: assert property (s_sleep_op |=> state_r == ST_IGNORE)
    else $error("instruction decoded while sleeping");
  wake_release_a: assert property (s_wake_armed |=> waking ##[1:WAKE_MAX] !sleep_r)
    else $error("sleep flag not released after wake delay");
  wake_hold_a: assert property (s_wake_armed |=> sleep_r [*8])
    else $error("sleep released before wake delay");
  busy_wake_a: assert property (op_done && busy_any && !sleep_r && !waking
                                && op_full == `SFI_OP_WAKE_ID |=> state_r == ST_IGNORE)
    else $error("wake code decoded during busy cycle");
  long_id_a: assert property (op_done && !erase_prog_busy_in && !sleep_r && !waking
                              && op_full == `SFI_OP_LONG_ID |=> sh_r == MAKER_ID)
    else $error("long identifier does not start with maker");
  order_swap_a: assert property (arg_done && cmd_r == CMD_MAKER_PART
                                 && arg_full == `SFI_ORDER_SWAP_ADDR |=> sh_r == PART_ID)
    else $error("address one did not put part byte first");
  deselect_end_a: assert property (cs_rise |=> state_r == ST_IDLE && !spi_do_oe_out)
    else $error("output not ended on deselect");
  seal_block_a: assert property (secure_r && seal_bit_in |-> !pe_allow_out)
    else $error("program or erase allowed while sealed");
  exit_secure_a: assert property (secure_exit |=> !secure_mode_out)
    else $error("secure mode kept after write disable");
  sleep_entry_a: assert property ($rose(sleep_r) |-> $past(sleep_entry))
    else $error("sleep entered without sleep code");
  protect_view_a: assert property (secure_r |-> status_protect_view_out == seal_bit_in)
    else $error("protect bit not showing seal in secure mode");

endmodule // sfi_instr

`default_nettype wire

// ---- tb/sfi_host_model.sv ----
// SPI host model: drives the serial bus in mode 0 with a 160 ns serial clock.
// Assumes the bench calls frame() just after a falling edge of clk_in.
`timescale 1ns/100ps
`default_nettype none

module sfi_host_model (
  // Clock
  input  wire logic clk_in,
  // Serial bus
  output var  logic cs_n_out,
  output var  logic sclk_out,
  output var  logic di_out,
  input  wire logic do_in,
  input  wire logic do_oe_in
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    di_out   = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One frame: opcode, argument bits, then out_bits read back MSB first
  task automatic frame(input logic [7:0] op, input logic [23:0] arg, input int arg_bits,
                       input int out_bits, output logic [31:0] rx, output logic oe_seen);
    logic [31:0] tx;
    int          i;
    tx = {op, arg};
    rx = 32'h00000000;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (i = 0; i < 8 + arg_bits + out_bits; i++) begin
      di_out = (i < 8 + arg_bits) ? tx[31 - i] : ~di_out;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      // Taken late in the high phase: the bit stands until the next fall
      if (i >= 8 + arg_bits) begin
        rx = {rx[30:0], do_in};
        oe_seen = oe_seen | do_oe_in;
      end
      sclk_out = 1'b0;
    end
    repeat (4) @(negedge clk_in);
    cs_n_out = 1'b1;
    // Deselected, the data line carries nothing, so it toggles
    repeat (8) begin
      @(negedge clk_in);
      di_out = ~di_out;
    end
  endtask
endmodule // sfi_host_model

`default_nettype wire

// ---- tb/sfi_tb.sv ----
// Self-checking bench of the serial flash instruction block.
// Assumes the design asserts its own rules; this bench drives every mode.
`timescale 1ns/100ps
`default_nettype none
`include "sfi_consts.svh"
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))

module testbench;
  import sfi_pkg::*;
  localparam logic [7:0] MK = 8'ha5;  // Arbitrary value
  localparam logic [7:0] TY = 8'h40;  // Arbitrary value
  localparam logic [7:0] CP = 8'h17;  // Arbitrary value
  localparam logic [7:0] PT = 8'h3c;  // Arbitrary value
  typedef struct {
    logic [7:0] op; logic [23:0] arg; int argb; int outb; logic [31:0] exp;
  } sfi_tb_id_s;
  typedef struct {
    logic seal; logic [2:0] bp; logic [23:0] addr; logic [7:0] op; logic er, ok, hit;
  } sfi_tb_gate_s;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, cs_n, sclk, di, do_w, oe;
  logic        ep_busy = 1'b0, sw_busy = 1'b0, sp_bit = 1'b0, seal = 1'b0, pe_er = 1'b0;
  logic [2:0]  bp = 3'h0;
  logic [23:0] pe_addr = 24'h000000;
  logic [7:0]  pe_op = 8'h00;
  logic        sleep, waking, secure, sp_view, hit, allow, seal_pgm, discard, seen;
  logic [31:0] rx;
  int          failures = 0, checks_done = 0, pulses = 0, wake_cnt = 0, n;
  sfi_tb_id_s ids[6] = '{'{8'hab, 0, 24, 8, PT}, '{8'hab, 0, 24, 16, {PT, PT}},
    '{8'h90, 0, 24, 16, {MK, PT}}, '{8'h90, 1, 24, 16, {PT, MK}},
    '{8'h9f, 0, 0, 24, {MK, TY, CP}}, '{8'h9f, 0, 0, 32, {MK, TY, CP, MK}}};
  sfi_tb_gate_s gates[7] = '{'{0, 0, 24'h07f000, 8'h20, 1, 1, 1},
    '{0, 0, 24'h07f0ff, 8'h02, 0, 1, 1}, '{0, 0, 24'h07f100, 8'hd8, 1, 1, 0},
    '{0, 0, 24'h07f000, 8'hd8, 1, 0, 1}, '{0, 1, 24'h07f000, 8'h02, 0, 0, 1},
    '{1, 0, 24'h010000, 8'h02, 0, 0, 0}, '{1, 0, 24'h07f000, 8'h20, 1, 0, 1}};

  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (seal_pgm === 1'b1) pulses++;
    if (waking === 1'b1) wake_cnt++;
  end

  sfi_host_model sfi_host_model_inst (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk),
    .di_out(di), .do_in(do_w), .do_oe_in(oe));
  sfi_instr #(.MAKER_ID(MK), .TYPE_ID(TY), .CAP_ID(CP), .PART_ID(PT)) sfi_instr_inst (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
    .spi_di_in(di), .spi_do_out(do_w), .spi_do_oe_out(oe), .erase_prog_busy_in(ep_busy),
    .status_write_busy_in(sw_busy), .block_protect_bits_in(bp),
    .status_protect_bit_in(sp_bit), .seal_bit_in(seal), .pe_addr_in(pe_addr),
    .pe_opcode_in(pe_op), .pe_is_erase_in(pe_er), .sleep_out(sleep), .waking_out(waking),
    .secure_mode_out(secure), .status_protect_view_out(sp_view),
    .secure_sector_hit_out(hit), .pe_allow_out(allow), .seal_program_out(seal_pgm),
    .status_data_discard_out(discard));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] arg, input int ab, input int ob);
    sfi_host_model_inst.frame(op, arg, ab, ob, rx, seen);
  endtask

  // Host keeps chip select high for the whole wake delay, bounded
  task automatic wait_wake();
    for (n = 0; n < 400 && waking !== 1'b0; n++) @(negedge clk_in);
    if (n == 400) begin
      failures++;
      report_and_stop();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge clk_in);
    `CHK("sleep at reset", 1'b0, sleep);
    `CHK("secure at reset", 1'b0, secure);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    foreach (ids[k]) begin
      run(ids[k].op, ids[k].arg, ids[k].argb, ids[k].outb);
      `CHK("id bytes", ids[k].exp, rx);
    end
    `CHK("no wake delay when awake", 0, wake_cnt);
    run(`SFI_OP_SLEEP, 0, 0, 0);
    `CHK("sleep entry", 1'b1, sleep);
    // Asleep the host keeps to the short identifier read, never the long one
    run(`SFI_OP_MAKER_PART, 0, 24, 16);
    `CHK("asleep output", 1'b0, seen);
    wake_cnt = 0;
    run(`SFI_OP_WAKE_ID, 0, 0, 0);
    wait_wake();
    `CHK("short wake cycles", `SFI_SHORT_WAKE_CYC, wake_cnt);
    `CHK("awake after wake", 1'b0, sleep);
    run(`SFI_OP_SLEEP, 0, 0, 0);
    wake_cnt = 0;
    run(`SFI_OP_WAKE_ID, 0, 24, 8);
    `CHK("part id from sleep", PT, rx);
    wait_wake();
    `CHK("long wake cycles", `SFI_LONG_WAKE_CYC, wake_cnt);
    sw_busy = 1'b1;
    run(`SFI_OP_WAKE_ID, 0, 24, 8);
    `CHK("wake id while busy", 1'b0, seen);
    {sw_busy, ep_busy} = 2'b01;
    run(`SFI_OP_LONG_ID, 0, 0, 24);
    `CHK("long id while busy", 1'b0, seen);
    run(`SFI_OP_SLEEP, 0, 0, 0);
    `CHK("sleep refused while busy", 1'b0, sleep);
    ep_busy = 1'b0;
    run(`SFI_OP_LONG_ID, 0, 0, 12);
    `CHK("output off after deselect", 1'b0, oe);
    run(`SFI_OP_LONG_ID, 0, 0, 8);
    `CHK("fresh frame after cut", MK, rx);
    sp_bit = 1'b1;
    #1 `CHK("protect bit outside secure", 1'b1, sp_view);
    bp = 3'h0;
    run(`SFI_OP_SECURE_ENTER, 0, 0, 0);
    `CHK("secure entry", 1'b1, secure);
    {seal, sp_bit} = 2'b10;
    #1 `CHK("seal shown as protect", 1'b1, sp_view);
    foreach (gates[k]) begin
      @(negedge clk_in);
      {seal, bp, pe_addr, pe_op, pe_er} = {gates[k].seal, gates[k].bp, gates[k].addr,
        gates[k].op, gates[k].er};
      #1 `CHK("gate allow", gates[k].ok, allow);
      `CHK("sector hit", gates[k].hit, hit);
    end
    {seal, bp} = 4'h0;
    run(`SFI_OP_STATUS_WRITE, 24'h550000, 8, 0);
    `CHK("seal program pulse", 1, pulses);
    `CHK("status data discarded", 1'b1, discard);
    run(`SFI_OP_WRITE_DISABLE, 0, 0, 0);
    `CHK("secure exit", 1'b0, secure);
    // Reset in mid-run while asleep and in secure mode clears both flags
    run(`SFI_OP_SECURE_ENTER, 0, 0, 0);
    run(`SFI_OP_SLEEP, 0, 0, 0);
    `CHK("asleep before reset", 1'b1, sleep);
    reset_n_in = 1'b0;
    repeat (2) @(negedge clk_in);
    `CHK("sleep after mid reset", 1'b0, sleep);
    `CHK("secure after mid reset", 1'b0, secure);
    reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    run(`SFI_OP_LONG_ID, 0, 0, 24);
    `CHK("long id after mid reset", {MK, TY, CP}, rx);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire
